// ==== hw/tfsl_top.sv ====
// Thermal fan speed loop top: registers, thermal loop, alarms and fan failure.
//
// Functional notes
// [RULE1] Latch a new temperature sample every 250 ms conversion period.
// [RULE2] Compare samples with limits to drive critical and alarm outputs.
// [RULE3] Update rate codes 0..6 copy samples every 16 s down to 0.25 s.
// [RULE4] Speed word holds update minus threshold, 0.5 degree steps, bit 5 is 16 degrees.
// [RULE5] Excess above 32 degrees sets overflow bit 6 and all lower bits.
// [RULE6] Speed word writes ignored while thermal loop is closed.
// [RULE7] Configuration bit 3 low closes thermal loop, high opens it.
// [RULE8] Gain field picks 8, 16 or 32 degree span in 16, 32, 64 steps.
// [RULE9] Fan open loop: speed word sets voltage; 40h forces full voltage.
// [RULE10] Fan closed loop: zero is stop; full is 10h, 20h or 3Fh by gain.
// [RULE11] Up/down counter counts up on reference, down on prescaled tach pulses.
// [RULE12] Reference derived at 8415 Hz, divided by full scale limited 127..255.
// [RULE13] Reference further divided by speed word to set desired speed.
// [RULE14] Tach pulses pass a 1/2/4/8 prescaler held in divisor register.
// [RULE15] Host picks prescaler so full-speed pulses fall in 33..66 Hz.
// [RULE16] Six counter stages directly drive the 6-bit fan DAC.
// [RULE17] Larger counter values in closed loop mean higher speed and voltage.
// [RULE18] Selecting fan open loop forces the thermal loop open too.
// [RULE19] Fan failure when measured tach count exceeds programmed limit.
// [RULE20] Fans without tach use commutation current pulses as speed pulses.
// [RULE21] Speed word bit 7 reads zero; all its bits reset to zero.
// [RULE22] Gain register bit 0 high selects fan open-loop voltage mode.
// [RULE23] Gain register bit 1 high uses current pulses instead of tach.
// [RULE24] Divisor low bits: 00 by 1, 01 by 2, 10 by 4, 11 by 8.
// [RULE25] Only low three bits of update-rate register matter.
// [RULE26] Up/down counter saturates at zero and maximum code.
// [RULE27] Sample at or below threshold gives speed word zero in closed loop.
`timescale 1ns/100ps
module tfsl_top
   import tfsl_pkg::*;
#(
   parameter int CONV_DIV = CONV_CYCLES,
   parameter int REF_DIV  = REF_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_cmd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic [9:0] temp_in,
   input  wire logic       tach_in,
   input  wire logic       current_pulse_in,
   output logic      [5:0] fan_dac,
   output logic            critical_temp_output,
   output logic            alarm_out,
   output logic            fan_fail
);
   logic [9:0]  temp_m_reg, temp_s_reg;
   logic [1:0]  tach_sync_reg, curr_sync_reg;
   logic [23:0] conv_cnt_reg;
   logic [5:0]  upd_cnt_reg;
   logic [9:0]  temp_sample_reg, update_reg;
   logic [7:0]  fan_speed_control_reg, fan_gain_reg, fan_full_scale_reg;
   logic [7:0]  speed_pulse_divisor_reg, fan_update_rate_reg, cfg_reg;
   logic [7:0]  fan_start_threshold_reg, high_limit_reg, low_limit_reg;
   logic [7:0]  critical_hysteresis_reg, critical_limit_reg, tach_limit_reg;
   logic [7:0]  reg_rdata_reg;
   logic        crit_reg, alarm_reg, fail_reg;
   logic [7:0]  tach_count;

   wire logic wr_fsc  = reg_wr && reg_cmd == CMD_WR_FSC;
   wire logic wr_fg   = reg_wr && reg_cmd == CMD_WR_FG;
   wire logic wr_fs   = reg_wr && reg_cmd == CMD_WR_FS;
   wire logic wr_fcd  = reg_wr && reg_cmd == CMD_WR_FCD;
   wire logic wr_cfg  = reg_wr && reg_cmd == CMD_WR_CFG;
   wire logic wr_fcr  = reg_wr && reg_cmd == CMD_WR_FCR;
   wire logic wr_fan_start_threshold = reg_wr && reg_cmd == CMD_WR_FAN_START_THRESHOLD;
   wire logic wr_high = reg_wr && reg_cmd == CMD_WR_HIGH;
   wire logic wr_low  = reg_wr && reg_cmd == CMD_WR_LOW;
   wire logic wr_hyst = reg_wr && reg_cmd == CMD_WR_HYST;
   wire logic wr_crit = reg_wr && reg_cmd == CMD_WR_CRIT;
   wire logic wr_tlim = reg_wr && reg_cmd == CMD_WR_TLIM;

   wire logic fan_open = fan_gain_reg[FG_DRV_OPEN_BIT];
   wire logic thermal_closed = !cfg_reg[CFG_THERM_OPEN_BIT]; // [RULE7]
   wire logic [1:0] gain = fan_gain_reg[FG_GAIN_LSB +: 2];
   wire logic [6:0] gain_full = tfsl_gain_full(gain);

   // Conversion timing and update-rate selection.
   wire logic       conv_tick = (conv_cnt_reg == 24'(CONV_DIV - 1));
   wire logic [2:0] rate_code = (fan_update_rate_reg[2:0] > FCR_MAX_CODE) ?
                                FCR_MAX_CODE : fan_update_rate_reg[2:0]; // [RULE25]
   wire logic [5:0] upd_last = 6'((7'h01 << (FCR_MAX_CODE - rate_code)) - 7'h01); // [RULE3]
   wire logic       upd_tick = conv_tick && (upd_cnt_reg >= upd_last);

   // Excess of the update register over the threshold, in half degrees.
   wire logic signed [10:0] excess = $signed({update_reg[9], update_reg}) -
                                     $signed({fan_start_threshold_reg[7],
                                              fan_start_threshold_reg, 1'b0});
   wire logic [6:0] fsc_thermal = (excess <= 11'sd0) ? 7'h00 : // [RULE27]
                                  (excess > $signed(EXCESS_OVF)) ? FSC_OVERFLOW : // [RULE5]
                                  (excess >= $signed({4'h0, gain_full})) ? gain_full : // [RULE8]
                                  excess[6:0]; // [RULE4] [RULE10]

   // Whole-degree part of the sample for limit compares.
   wire logic signed [8:0] temp_deg = $signed(temp_sample_reg[9:1]);
   wire logic over_crit = temp_deg > $signed({critical_limit_reg[7], critical_limit_reg});
   wire logic under_hyst = temp_deg < $signed({critical_hysteresis_reg[7],
                                               critical_hysteresis_reg});
   wire logic out_window = temp_deg > $signed({high_limit_reg[7], high_limit_reg}) ||
                           temp_deg < $signed({low_limit_reg[7], low_limit_reg});
   wire logic fan_above = temp_deg > $signed({fan_start_threshold_reg[7],
                                              fan_start_threshold_reg});

   wire logic [7:0] status = {1'b0, alarm_reg, fan_open || fan_dac == 6'h3f, out_window,
                              fan_above, 1'b0, crit_reg, fail_reg};

   wire logic [7:0] rd_mux =
      (reg_cmd == CMD_RD_FSC)    ? {1'b0, fan_speed_control_reg[6:0]} : // [RULE21]
      (reg_cmd == CMD_RD_FG)     ? fan_gain_reg :
      (reg_cmd == CMD_RD_FS)     ? fan_full_scale_reg :
      (reg_cmd == CMD_RD_FCD)    ? speed_pulse_divisor_reg :
      (reg_cmd == CMD_RD_CFG)    ? cfg_reg :
      (reg_cmd == CMD_RD_FCR)    ? fan_update_rate_reg :
      (reg_cmd == CMD_RD_FAN_START_THRESHOLD)   ? fan_start_threshold_reg :
      (reg_cmd == CMD_RD_HIGH)   ? high_limit_reg :
      (reg_cmd == CMD_RD_LOW)    ? low_limit_reg :
      (reg_cmd == CMD_RD_HYST)   ? critical_hysteresis_reg :
      (reg_cmd == CMD_RD_CRIT)   ? critical_limit_reg :
      (reg_cmd == CMD_RD_TLIM)   ? tach_limit_reg :
      (reg_cmd == CMD_RD_STATUS) ? status :
      (reg_cmd == CMD_RD_TACH)   ? tach_count :
      (reg_cmd == CMD_RD_TEMP)   ? temp_sample_reg[9:2] : 8'h00;

   // Pin synchronisers; the ADC word is held stable across a conversion.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         temp_m_reg    <= 10'h0;
         temp_s_reg    <= 10'h0;
         tach_sync_reg <= 2'b00;
         curr_sync_reg <= 2'b00;
      end else begin
         temp_m_reg    <= temp_in;
         temp_s_reg    <= temp_m_reg;
         tach_sync_reg <= {tach_sync_reg[0], tach_in};
         curr_sync_reg <= {curr_sync_reg[0], current_pulse_in};
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         conv_cnt_reg    <= 24'h0;
         upd_cnt_reg     <= 6'h0;
         temp_sample_reg <= 10'h0;
         update_reg      <= 10'h0;
      end else begin
         conv_cnt_reg <= conv_tick ? 24'h0 : conv_cnt_reg + 24'h1;
         if (conv_tick) begin
            temp_sample_reg <= temp_s_reg; // [RULE1]
            upd_cnt_reg     <= upd_tick ? 6'h0 : upd_cnt_reg + 6'h1;
         end
         if (upd_tick) begin
            update_reg <= temp_s_reg; // [RULE3]
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fan_speed_control_reg <= RST_FSC;
      end else if (thermal_closed) begin
         fan_speed_control_reg <= {1'b0, fsc_thermal}; // [RULE4] [RULE6]
      end else if (wr_fsc) begin
         fan_speed_control_reg <= {1'b0, reg_wdata[6:0]}; // [RULE21]
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fan_gain_reg            <= RST_FG;
         fan_full_scale_reg      <= RST_FS;
         speed_pulse_divisor_reg <= RST_FCD;
         fan_update_rate_reg     <= RST_FCR;
         cfg_reg                 <= RST_CFG;
      end else begin
         if (wr_fg) begin
            fan_gain_reg <= reg_wdata[FG_RSVD_BIT] ? reg_wdata :
                            {FG_RSVD_FORCE[7:5], reg_wdata[4:0]};
         end
         if (wr_fs) begin
            fan_full_scale_reg <= (reg_wdata < FS_MIN) ? FS_MIN : reg_wdata; // [RULE12]
         end
         if (wr_fcd) begin
            speed_pulse_divisor_reg <= reg_wdata;
         end
         if (wr_fcr) begin
            fan_update_rate_reg <= reg_wdata;
         end
         if (wr_fg && reg_wdata[FG_DRV_OPEN_BIT]) begin
            cfg_reg[CFG_THERM_OPEN_BIT] <= 1'b1; // [RULE18]
         end else if (wr_cfg) begin
            cfg_reg <= reg_wdata | {4'h0, fan_open, 3'h0}; // [RULE18]
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fan_start_threshold_reg <= RST_FAN_START_THRESHOLD;
         high_limit_reg          <= RST_HIGH;
         low_limit_reg           <= RST_LOW;
         critical_hysteresis_reg <= RST_HYST;
         critical_limit_reg      <= RST_CRIT;
         tach_limit_reg          <= RST_TLIM;
      end else begin
         if (wr_fan_start_threshold) fan_start_threshold_reg <= reg_wdata;
         if (wr_high) high_limit_reg <= reg_wdata;
         if (wr_low) low_limit_reg <= reg_wdata;
         if (wr_hyst) critical_hysteresis_reg <= reg_wdata;
         if (wr_crit) critical_limit_reg <= reg_wdata;
         if (wr_tlim) tach_limit_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         crit_reg      <= 1'b0;
         alarm_reg     <= 1'b0;
         fail_reg      <= 1'b0;
         reg_rdata_reg <= 8'h00;
      end else begin
         crit_reg      <= over_crit || (crit_reg && !under_hyst); // [RULE2]
         alarm_reg     <= out_window; // [RULE2]
         fail_reg      <= fan_open || (tach_count > tach_limit_reg); // [RULE19]
         if (reg_rd) begin
            reg_rdata_reg <= rd_mux;
         end
      end
   end

   tfsl_speed_loop #(
      .REF_DIV (REF_DIV)
   ) u_loop (
      .clk            (clk),
      .reset          (reset),
      .fs_code        (fan_full_scale_reg),
      .fan_speed_control            (fan_speed_control_reg[6:0]),
      .gain           (gain),
      .fan_open       (fan_open),
      .use_current    (fan_gain_reg[FG_FB_CURR_BIT]),
      .div_sel        (speed_pulse_divisor_reg[1:0]),
      .tach_s         (tach_sync_reg[1]),
      .curr_s         (curr_sync_reg[1]),
      .dac_reg        (fan_dac),
      .tach_count_reg (tach_count)
   );

   assign reg_rdata = reg_rdata_reg;
   assign critical_temp_output = crit_reg;
   assign alarm_out = alarm_reg;
   assign fan_fail = fail_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_fsc_bit_seven: assert property (fan_speed_control_reg[7] == 1'b0) // [RULE21]
      else $error("speed word bit 7 set");
   chk_sample_on_tick: assert property (conv_tick |=> temp_sample_reg == $past(temp_s_reg)) // [RULE1]
      else $error("sample not latched on conversion tick");
   chk_fsc_read_only: assert property (thermal_closed && wr_fsc |=> // [RULE6]
                                       fan_speed_control_reg == {1'b0, $past(fsc_thermal)})
      else $error("speed word written while thermal loop closed");
   chk_overflow_set: assert property (thermal_closed && excess > $signed(EXCESS_OVF) |=> // [RULE5]
                                      fan_speed_control_reg == 8'h7f)
      else $error("overflow not reported");
   chk_below_zero: assert property (thermal_closed && excess <= 11'sd0 |=> // [RULE27]
                                    fan_speed_control_reg == 8'h00)
      else $error("speed word not zero below threshold");
   chk_open_forces: assert property (wr_fg && reg_wdata[0] |=> cfg_reg[3] ##1 cfg_reg[3]) // [RULE18]
      else $error("fan open loop did not open thermal loop");
   chk_fs_floor: assert property (fan_full_scale_reg >= FS_MIN) // [RULE12]
      else $error("full scale below floor");
   chk_fail_flag: assert property (!fan_open && tach_count > tach_limit_reg |=> fan_fail) // [RULE19]
      else $error("fan failure missed");
   chk_crit_out: assert property (over_crit |=> critical_temp_output) // [RULE2]
      else $error("critical output not raised");
   chk_dac_full_open: assert property (fan_open && fan_speed_control_reg[6] && // [RULE9]
                                       $stable(fan_speed_control_reg) |=> fan_dac == 6'h3f)
      else $error("full voltage not forced");
   chk_dac_no_wrap: assert property (!fan_open && $past(!fan_open) && // [RULE26]
                                     $past(fan_dac) == 6'h3f |-> fan_dac != 6'h00)
      else $error("counter wrapped");

   cov_update_tick: cover property (upd_tick && thermal_closed);
   cov_overflow: cover property (fan_speed_control_reg[6] && thermal_closed);
   cov_fan_fail: cover property (!fan_open && fan_fail);
   cov_open_loop: cover property (fan_open && fan_dac == 6'h3f);

endmodule

// ==== hw/tfsl_pkg.sv ====
// Constants, command codes and shared helpers of the thermal fan speed loop.
package tfsl_pkg;

   // Read and write command codes of the register port.
   localparam logic [7:0] CMD_RD_FSC = 8'h15, CMD_WR_FSC = 8'h1a;
   localparam logic [7:0] CMD_RD_FG = 8'h16, CMD_WR_FG = 8'h1b;
   localparam logic [7:0] CMD_RD_FCD = 8'h1d, CMD_WR_FCD = 8'h1e;
   localparam logic [7:0] CMD_RD_FS = 8'h1f, CMD_WR_FS = 8'h20;
   localparam logic [7:0] CMD_RD_CFG = 8'h40, CMD_WR_CFG = 8'h41;
   localparam logic [7:0] CMD_RD_FCR = 8'h42, CMD_WR_FCR = 8'h43;
   localparam logic [7:0] CMD_RD_FAN_START_THRESHOLD = 8'h44, CMD_WR_FAN_START_THRESHOLD = 8'h45;
   localparam logic [7:0] CMD_RD_HIGH = 8'h46, CMD_WR_HIGH = 8'h47;
   localparam logic [7:0] CMD_RD_LOW = 8'h48, CMD_WR_LOW = 8'h49;
   localparam logic [7:0] CMD_RD_HYST = 8'h4a, CMD_WR_HYST = 8'h4b;
   localparam logic [7:0] CMD_RD_CRIT = 8'h4c, CMD_WR_CRIT = 8'h4d;
   localparam logic [7:0] CMD_RD_TLIM = 8'h4e, CMD_WR_TLIM = 8'h4f;
   localparam logic [7:0] CMD_RD_STATUS = 8'h50, CMD_RD_TACH = 8'h51;
   localparam logic [7:0] CMD_RD_TEMP = 8'h52;

   // Reset values.
   localparam logic [7:0] RST_FSC = 8'h00, RST_FG = 8'h80, RST_FS = 8'hff;
   localparam logic [7:0] RST_FCD = 8'h01, RST_FCR = 8'h02, RST_CFG = 8'h00;
   localparam logic [7:0] RST_FAN_START_THRESHOLD = 8'h28, RST_HIGH = 8'h7f, RST_LOW = 8'hc9;
   localparam logic [7:0] RST_HYST = 8'h5f, RST_CRIT = 8'h64, RST_TLIM = 8'hff;

   // Field positions.
   localparam int CFG_THERM_OPEN_BIT = 3;
   localparam int FG_DRV_OPEN_BIT = 0;
   localparam int FG_FB_CURR_BIT = 1;
   localparam int FG_GAIN_LSB = 5;
   localparam int FG_RSVD_BIT = 7;
   localparam int FSC_OVF_BIT = 6;
   localparam logic [7:0] FG_RSVD_FORCE = 8'h80;

   // Limits and codes.
   localparam logic [7:0] FS_MIN = 8'h7f;
   localparam logic [2:0] FCR_MAX_CODE = 3'h6;
   localparam logic [6:0] FSC_OVERFLOW = 7'h7f;
   localparam logic [6:0] FSC_FULL_VOLT = 7'h40;
   localparam logic [10:0] EXCESS_OVF = 11'h040;

   // Timing.
   localparam longint CLK_HZ = 40_000_000;
   localparam longint CONV_PERIOD_MS = 250;
   localparam longint REF_HZ = 8415;
   localparam int CONV_CYCLES = int'(CLK_HZ * CONV_PERIOD_MS / 1000);
   localparam int REF_CYCLES = int'(CLK_HZ / REF_HZ);

   // Full-speed code of the speed word for a gain setting.
   function automatic logic [6:0] tfsl_gain_full(input logic [1:0] gain);
      case (gain)
         2'b00:   tfsl_gain_full = 7'h10;
         2'b01:   tfsl_gain_full = 7'h20;
         default: tfsl_gain_full = 7'h3f;
      endcase
   endfunction

endpackage

// ==== hw/tfsl_speed_loop.sv ====
// Fan speed regulator: reference divider, tach prescaler, up/down counter and DAC code.
`timescale 1ns/100ps
module tfsl_speed_loop
   import tfsl_pkg::*;
#(
   parameter int REF_DIV = REF_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [7:0] fs_code,
   input  wire logic [6:0] fan_speed_control,
   input  wire logic [1:0] gain,
   input  wire logic       fan_open,
   input  wire logic       use_current,
   input  wire logic [1:0] div_sel,
   input  wire logic       tach_s,
   input  wire logic       curr_s,
   output logic      [5:0] dac_reg,
   output logic      [7:0] tach_count_reg
);
   logic [12:0] ref_cnt_reg;
   logic [7:0]  fs_cnt_reg;
   logic [6:0]  acc_reg;
   logic [2:0]  pre_cnt_reg;
   logic [7:0]  period_reg;
   logic        fb_d_reg;

   wire logic       ref_tick = (ref_cnt_reg == 13'(REF_DIV - 1));
   wire logic       fs_tick = ref_tick && (fs_cnt_reg >= fs_code - 8'h01);
   wire logic [6:0] full = tfsl_gain_full(gain);
   wire logic [6:0] fsc_eff = (fan_speed_control > full) ? full : fan_speed_control;
   wire logic [7:0] acc_sum = {1'b0, acc_reg} + {1'b0, fsc_eff};
   wire logic       up_tick = fs_tick && (acc_sum >= {1'b0, full});
   wire logic       fb = use_current ? curr_s : tach_s; // [RULE20] [RULE23]
   wire logic       fb_rise = fb && !fb_d_reg;
   wire logic [2:0] pre_mask = 3'((4'h1 << div_sel) - 4'h1); // [RULE24]
   wire logic       dn_tick = !fan_open && fb_rise && (pre_cnt_reg == pre_mask); // [RULE14]

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ref_cnt_reg <= 13'h0;
         fs_cnt_reg  <= 8'h0;
         acc_reg     <= 7'h0;
      end else begin
         ref_cnt_reg <= ref_tick ? 13'h0 : ref_cnt_reg + 13'h1; // [RULE12]
         if (ref_tick) begin
            fs_cnt_reg <= fs_tick ? 8'h0 : fs_cnt_reg + 8'h1; // [RULE12]
         end
         if (fs_tick) begin
            acc_reg <= up_tick ? 7'(acc_sum - {1'b0, full}) : acc_sum[6:0]; // [RULE13]
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fb_d_reg    <= 1'b0;
         pre_cnt_reg <= 3'h0;
      end else begin
         fb_d_reg <= fb;
         if (fb_rise) begin
            pre_cnt_reg <= (pre_cnt_reg >= pre_mask) ? 3'h0 : pre_cnt_reg + 3'h1;
         end
      end
   end

   // Counter stages drive the DAC directly; open loop loads the speed word instead.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dac_reg <= 6'h0;
      end else if (fan_open) begin
         dac_reg <= fan_speed_control[FSC_OVF_BIT] ? 6'h3f : fan_speed_control[5:0]; // [RULE9] [RULE22]
      end else if (up_tick && !dn_tick && dac_reg != 6'h3f) begin
         dac_reg <= dac_reg + 6'h1; // [RULE11] [RULE16] [RULE17] [RULE26]
      end else if (dn_tick && !up_tick && dac_reg != 6'h0) begin
         dac_reg <= dac_reg - 6'h1; // [RULE11] [RULE26]
      end
   end

   // Reference ticks between prescaled feedback pulses, saturating.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         period_reg     <= 8'h0;
         tach_count_reg <= 8'h0;
      end else if (dn_tick) begin
         tach_count_reg <= period_reg;
         period_reg     <= 8'h0;
      end else if (ref_tick && period_reg != 8'hff) begin
         period_reg <= period_reg + 8'h1;
      end
   end

endmodule

// ==== tb/tfsl_fan_model.sv ====
// Behavioural fan whose tach rate follows the DAC code it is driven with.
`timescale 1ns/100ps
module tfsl_fan_model #(
   parameter int STEP = 3000
) (
   input  wire logic       clk,
   input  wire logic [5:0] fan_dac,
   output logic            tach,
   output logic            curr
);
   int acc = 0;
   initial tach = 1'b1;
   initial curr = 1'b0;
   // A stopped fan leaves the tach line at its last level, which is high after an even number of toggles.
   always @(posedge clk) begin
      curr <= 1'b0;
      if (acc + fan_dac >= STEP) begin
         acc  <= acc + fan_dac - STEP;
         tach <= ~tach;
         curr <= 1'b1;
      end else begin
         acc <= acc + fan_dac;
      end
   end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the thermal fan speed loop top.
`timescale 1ns/100ps
module tb_top
   import tfsl_pkg::*;
;
   typedef struct packed {
      logic [7:0] wc, wd, rc, rd;
      logic       dc;
      logic [5:0] dv;
   } tfsl_row_s;
   logic       clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_cmd = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
   logic [9:0] temp_in = 10'h028;
   logic [5:0] fan_dac;
   logic       tach_in, current_pulse_in, critical_temp_output, alarm_out, fan_fail;
   int         miscompares = 0, compares = 0, i;
   tfsl_row_s  rows [10] = '{
      '{8'h1a, 8'h33, 8'h15, 8'h00, 1'b0, 6'h00},
      '{8'h20, 8'h10, 8'h1f, 8'h7f, 1'b0, 6'h00},
      '{8'h1e, 8'h03, 8'h1d, 8'h03, 1'b0, 6'h00},
      '{8'h41, 8'h08, 8'h40, 8'h08, 1'b0, 6'h00},
      '{8'h1a, 8'h85, 8'h15, 8'h05, 1'b0, 6'h00},
      '{8'h1b, 8'h01, 8'h16, 8'h81, 1'b0, 6'h00},
      '{8'h41, 8'h00, 8'h40, 8'h08, 1'b0, 6'h00},
      '{8'h1a, 8'h40, 8'h15, 8'h40, 1'b1, 6'h3f},
      '{8'h1a, 8'h21, 8'h15, 8'h21, 1'b1, 6'h21},
      '{8'h1a, 8'h3f, 8'h33, 8'h00, 1'b1, 6'h3f}};
   tfsl_top #(.CONV_DIV(64), .REF_DIV(4)) dut (
      .clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .temp_in(temp_in), .tach_in(tach_in),
      .current_pulse_in(current_pulse_in), .fan_dac(fan_dac),
      .critical_temp_output(critical_temp_output), .alarm_out(alarm_out), .fan_fail(fan_fail));
   tfsl_fan_model fan (.clk(clk), .fan_dac(fan_dac), .tach(tach_in), .curr(current_pulse_in));
   always #12.5 clk = ~clk;
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic final_report();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_flag(input logic got, input logic exp);
      cmp_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic bound(input int n, input int lim);
      if (n >= lim) begin
         miscompares++;
         $display("wait bound used up at t=%0t", $time);
         final_report();
      end
   endtask
   // Requests start 2 ns after an edge and are held across the sampling edge.
   task automatic reg_write(input logic [7:0] c, input logic [7:0] d);
      reg_wr = 1'b1;
      reg_cmd = c;
      reg_wdata = d;
      cycles(1);
      reg_wr = 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] c, output logic [7:0] d);
      reg_rd = 1'b1;
      reg_cmd = c;
      cycles(1);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   task automatic poll_fsc(input logic [7:0] old);
      int n;
      for (n = 0; n < 1200; n++) begin
         reg_read(CMD_RD_FSC, rv);
         if (rv !== old) break;
      end
      bound(n, 1200);
   endtask
   task automatic reset_dut();
      reset = 1'b1;
      cycles(2);
      reset = 1'b0;
   endtask
   initial begin
      #2;
      reset_dut();
      foreach (rows[k]) begin
         reg_write(rows[k].wc, rows[k].wd);
         reg_read(rows[k].rc, rv);
         cmp_byte(rv, rows[k].rd);
         cycles(2);
         if (rows[k].dc) cmp_byte({2'b00, fan_dac}, {2'b00, rows[k].dv});
      end
      cmp_flag(fan_fail, 1'b1);
      $display("test register table done");
      reset_dut();
      reg_read(CMD_RD_FSC, rv);
      cmp_byte(rv, 8'h00);
      reg_read(CMD_RD_FCR, rv);
      cmp_byte(rv, 8'h02);
      reg_read(CMD_RD_FCD, rv);
      cmp_byte(rv, 8'h01);
      cmp_byte({2'b00, fan_dac}, 8'h00);
      $display("test reset values done");
      temp_in = 10'h05a;
      poll_fsc(8'h00);
      cmp_byte(rv, 8'h0a);
      for (i = 0; i < 5000 && fan_dac === 6'h00; i++) cycles(1);
      bound(i, 5000);
      cmp_flag(fan_dac !== 6'h00, 1'b1);
      reg_write(CMD_WR_FCR, 8'h0e);
      temp_in = 10'h064;
      poll_fsc(8'h0a);
      cmp_byte(rv, 8'h10);
      // A wider gain span lets the 20 half-degree excess through unclamped.
      reg_write(CMD_WR_FG, 8'hc0);
      poll_fsc(8'h10);
      cmp_byte(rv, 8'h14);
      temp_in = 10'h0a0;
      poll_fsc(8'h14);
      cmp_byte(rv, 8'h7f);
      $display("test thermal loop done");
      temp_in = 10'h104;
      cycles(200);
      cmp_flag(alarm_out, 1'b1);
      cmp_flag(critical_temp_output, 1'b1);
      temp_in = 10'h028;
      cycles(200);
      cmp_flag(alarm_out, 1'b0);
      cmp_flag(critical_temp_output, 1'b0);
      $display("test limits done");
      // Slow tach at low codes makes the last steps down take long.
      for (i = 0; i < 60000 && fan_dac !== 6'h00; i++) cycles(1);
      bound(i, 60000);
      cycles(2000);
      cmp_byte({2'b00, fan_dac}, 8'h00);
      reg_write(CMD_WR_TLIM, 8'h01);
      for (i = 0; i < 5000 && fan_fail !== 1'b1; i++) cycles(1);
      bound(i, 5000);
      cmp_flag(fan_fail, 1'b1);
      $display("test fan fail done");
      final_report();
   end
endmodule
